// ---- rtl/irq_wake_defs.svh ----
// irq_wake_defs.svh: bit positions, reset values and sync depth for the interrupt and wakeup block
// assumes inclusion by bare name from rtl files
`ifndef IRQ_WAKE_DEFS_SVH
`define IRQ_WAKE_DEFS_SVH

`define NORM_W 16
`define ERR_W 16
`define SYNC_DEPTH 3
// normal status bit positions
`define NB_XFER_DONE 1
`define NB_WR_READY 4
`define NB_RD_READY 5
`define NB_INSERT 6
`define NB_REMOVE 7
`define NB_MEDIA_IRQ 8
// wakeup enable bit positions
`define WK_MEDIA_IRQ 0
`define WK_INSERT 1
`define WK_REMOVE 2
`define STATUS_RST 16'h0000
`define IRQ_ACTIVE_HIGH 1'b1

`endif

// ---- rtl/irq_wake_pkg.sv ----
// irq_wake_pkg: types shared by the interrupt and wakeup block
// assumes irq_wake_defs.svh is on the include path
`include "irq_wake_defs.svh"
package irq_wake_pkg;
    typedef logic [`NORM_W-1:0] norm_vec_t;
    typedef logic [`ERR_W-1:0] err_vec_t;
    typedef logic [2:0] wake_vec_t;
    typedef enum {PWR_NO_MEDIA, PWR_POWERED, PWR_CLOCKED} pwr_state_t;
endpackage

// ---- rtl/status_bank_if.sv ----
// status_bank_if: carrier between the top and one latched status bank
// assumes a single clock domain
`timescale 1ns/1ps
interface status_bank_if #(parameter int W = 16);
    logic [W-1:0] event_in;
    logic [W-1:0] stat_en;
    logic [W-1:0] sig_en;
    logic [W-1:0] clr_w1;
    logic [W-1:0] hold_mask;
    logic [W-1:0] status;
    logic pending;
    modport bank (input event_in, stat_en, sig_en, clr_w1, hold_mask, output status, pending);
    modport ctrl (output event_in, stat_en, sig_en, clr_w1, hold_mask, input status, pending);
endinterface

// ---- rtl/status_bank.sv ----
// status_bank: latched status bits with enable gating and write-one clear
// assumes events are already in sys_clk domain
`timescale 1ns/1ps
module status_bank #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // control side
    status_bank_if.bank bus
);
    logic [W-1:0] status_r;
    logic [W-1:0] status_nxt;
    logic [W-1:0] set_w;
    logic [W-1:0] clr_w;

    // hold bits ignore write-one and follow their source level
    assign set_w = bus.event_in & bus.stat_en;
    assign clr_w = (bus.clr_w1 & ~bus.hold_mask) | ~bus.stat_en;
    assign status_nxt = (bus.hold_mask & set_w)
        | (~bus.hold_mask & (set_w | (status_r & ~clr_w)));

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_r <= '0;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign bus.status = status_r;
    assign bus.pending = |(status_r & bus.sig_en);
endmodule // status_bank

// ---- rtl/irq_wakeup_ctrl.sv ----
// irq_wakeup_ctrl: interrupt, wakeup, transfer-done and power-state logic
// assumes media-side inputs arrive asynchronously; software bits are sys_clk signals
//
// Behaviour
// - event latches into status only while its status-enable is 1
// - clearing a status-enable clears its latched status bit
// - interrupt asserts while any status bit and its signal-enable are set
// - writing 1 to a status bit clears it
// - media interrupt status ignores write-one and follows the media request
// - media irq, insertion, removal drive wakeup via own enables
// - wakeup cause readable in normal status bits
// - slot summary bit is interrupt OR wakeup
// - wakeup needs status-enable, wakeup-enable and latched status, ignores signal-enable
// - output polarity selectable as an implementation choice
// - media-domain signals synchronised before use
// - all status bits held in the system clock domain
// - transfer-done sets at end of every read or write
// - read done only after all data reached host side
// - write done only after data sent and media busy ended
// - buffer writable/readable status and ready events reported
// - media clock never runs while media power is off
// - no media detected forces idle state, power and clock off
// - power condition bits readable
// - buffer-writable drops when pointer reaches block size
`timescale 1ns/1ps
`include "irq_wake_defs.svh"
module irq_wakeup_ctrl
    import irq_wake_pkg::*;
#(
    parameter int NW = `NORM_W,
    parameter int EW = `ERR_W,
    parameter int BLK_W = 12,
    parameter bit ACTIVE_HIGH = `IRQ_ACTIVE_HIGH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // software control
    input wire irq_wake_pkg::norm_vec_t norm_stat_en,
    input wire irq_wake_pkg::norm_vec_t norm_sig_en,
    input wire irq_wake_pkg::err_vec_t err_stat_en,
    input wire irq_wake_pkg::err_vec_t err_sig_en,
    input wire irq_wake_pkg::wake_vec_t wake_en,
    input wire irq_wake_pkg::norm_vec_t norm_clr_w1,
    input wire irq_wake_pkg::err_vec_t err_clr_w1,
    input wire logic int_clk_en,
    input wire logic power_on_req,
    input wire logic clk_on_req,
    input wire logic cmd_busy_in,
    // other sources, sys_clk domain
    input wire irq_wake_pkg::norm_vec_t norm_event,
    input wire irq_wake_pkg::err_vec_t err_event,
    // buffer side, sys_clk domain
    input wire logic dma_mode,
    input wire logic xfer_is_read,
    input wire logic xfer_start,
    input wire logic buf_wr_stb,
    input wire logic buf_rd_stb,
    input wire logic [BLK_W-1:0] block_size,
    // media side, asynchronous
    input wire logic media_irq_async,
    input wire logic media_present_async,
    input wire logic media_busy_async,
    input wire logic media_xfer_end_async,
    // status outputs
    output irq_wake_pkg::norm_vec_t norm_status,
    output irq_wake_pkg::err_vec_t err_status,
    output logic slot_summary,
    output logic buf_writable,
    output logic buf_readable,
    // power condition
    output logic int_clk_on,
    output logic media_present,
    output logic media_power_on,
    output logic media_clk_on,
    output logic media_bus_clock_en,
    output logic cmd_line_busy,
    output logic dat_line_busy,
    // system lines
    output logic irq_out,
    output logic wake_out
);
    // ------------------------------------------------------------
    // synchronisers for media-side levels
    // ------------------------------------------------------------
    localparam int N_ASYNC = 4;
    logic [N_ASYNC-1:0] async_in;
    logic [N_ASYNC-1:0] sync_lvl;
    logic irq_q_r;
    logic pres_q_r;
    logic busy_q_r;
    logic end_q_r;

    // a level counts once the second and third stages agree
    function automatic logic settle(input logic [`SYNC_DEPTH-1:0] s, input logic q);
        settle = (s[1] == s[2]) ? s[2] : q;
    endfunction

    assign async_in = {media_xfer_end_async, media_busy_async, media_present_async, media_irq_async};

    for (genvar g = 0; g < N_ASYNC; g++) begin : g_sync
        logic [`SYNC_DEPTH-1:0] stage_r;
        logic level_r;
        always_ff @(posedge sys_clk) begin
            if (sys_rst) begin
                stage_r <= '0;
                level_r <= 1'b0;
            end else begin
                stage_r <= {stage_r[`SYNC_DEPTH-2:0], async_in[g]};
                level_r <= settle(stage_r, level_r);
            end
        end
        assign sync_lvl[g] = level_r;
    end

    assign irq_q_r = sync_lvl[0];
    assign pres_q_r = sync_lvl[1];
    assign busy_q_r = sync_lvl[2];
    assign end_q_r = sync_lvl[3];

    // ------------------------------------------------------------
    // transfer tracking and buffer status
    // ------------------------------------------------------------
    logic pres_d_r;
    logic end_d_r;
    logic xfer_act_r;
    logic wr_en_r;
    logic rd_en_r;
    logic done_wait_r;
    logic [BLK_W-1:0] ptr_r;
    logic insert_ev;
    logic remove_ev;
    logic end_ev;
    logic done_ev;
    logic ptr_full;

    assign insert_ev = pres_q_r & ~pres_d_r;
    assign remove_ev = ~pres_q_r & pres_d_r;
    assign end_ev = end_q_r & ~end_d_r;
    assign ptr_full = (ptr_r + 1'b1) >= block_size;
    // read completes once host drained; write once media not busy
    assign done_ev = done_wait_r & (xfer_is_read ? (dma_mode | ~rd_en_r) : ~busy_q_r);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pres_d_r <= 1'b0;
            end_d_r <= 1'b0;
            xfer_act_r <= 1'b0;
            done_wait_r <= 1'b0;
            wr_en_r <= 1'b0;
            rd_en_r <= 1'b0;
            ptr_r <= '0;
        end else begin
            pres_d_r <= pres_q_r;
            end_d_r <= end_q_r;
            if (xfer_start) begin
                xfer_act_r <= 1'b1;
                ptr_r <= '0;
                wr_en_r <= ~xfer_is_read & ~dma_mode;
                rd_en_r <= xfer_is_read & ~dma_mode;
            end else if (wr_en_r & buf_wr_stb) begin
                ptr_r <= ptr_full ? '0 : ptr_r + 1'b1;
                if (ptr_full)
                    wr_en_r <= 1'b0;
            end else if (rd_en_r & buf_rd_stb) begin
                ptr_r <= ptr_full ? '0 : ptr_r + 1'b1;
                if (ptr_full)
                    rd_en_r <= 1'b0;
            end
            if (end_ev & xfer_act_r) begin
                done_wait_r <= 1'b1;
            end else if (done_ev) begin
                done_wait_r <= 1'b0;
                xfer_act_r <= xfer_start; // a new start wins over completion
            end
            if (remove_ev) begin
                xfer_act_r <= 1'b0;
                done_wait_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // status banks
    // ------------------------------------------------------------
    status_bank_if #(.W(NW)) nb ();
    status_bank_if #(.W(EW)) eb ();
    norm_vec_t norm_src;
    norm_vec_t media_hold;

    always_comb begin
        norm_src = norm_event;
        norm_src[`NB_XFER_DONE] = norm_event[`NB_XFER_DONE] | done_ev;
        norm_src[`NB_WR_READY] = norm_event[`NB_WR_READY] | (xfer_start & ~xfer_is_read & ~dma_mode);
        norm_src[`NB_RD_READY] = norm_event[`NB_RD_READY] | (xfer_start & xfer_is_read & ~dma_mode);
        norm_src[`NB_INSERT] = norm_event[`NB_INSERT] | insert_ev;
        norm_src[`NB_REMOVE] = norm_event[`NB_REMOVE] | remove_ev;
        norm_src[`NB_MEDIA_IRQ] = irq_q_r;
        media_hold = '0;
        media_hold[`NB_MEDIA_IRQ] = 1'b1;
    end

    assign nb.event_in = norm_src;
    assign nb.stat_en = norm_stat_en;
    assign nb.sig_en = norm_sig_en;
    assign nb.clr_w1 = norm_clr_w1;
    assign nb.hold_mask = media_hold;
    assign eb.event_in = err_event;
    assign eb.stat_en = err_stat_en;
    assign eb.sig_en = err_sig_en;
    assign eb.clr_w1 = err_clr_w1;
    assign eb.hold_mask = '0;

    status_bank #(.W(NW)) u_norm (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(nb));
    status_bank #(.W(EW)) u_err (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(eb));

    // ------------------------------------------------------------
    // interrupt, wakeup and power state
    // ------------------------------------------------------------
    logic irq_lvl;
    logic wake_lvl;
    logic power_lvl;
    logic clock_lvl;
    wake_vec_t wake_stat;
    pwr_state_t pwr_r;
    pwr_state_t pwr_nxt;

    assign irq_lvl = nb.pending | eb.pending;
    assign wake_stat = {nb.status[`NB_REMOVE], nb.status[`NB_INSERT], nb.status[`NB_MEDIA_IRQ]};
    assign wake_lvl = |(wake_stat & wake_en);
    assign power_lvl = (pwr_nxt != PWR_NO_MEDIA);
    assign clock_lvl = (pwr_nxt == PWR_CLOCKED);

    // losing media or power overrides any requested state
    always_comb begin
        case (pwr_r)
            PWR_NO_MEDIA: pwr_nxt = (pres_q_r & power_on_req) ? PWR_POWERED : PWR_NO_MEDIA;
            PWR_POWERED: pwr_nxt = (clk_on_req & int_clk_en) ? PWR_CLOCKED : PWR_POWERED;
            PWR_CLOCKED: pwr_nxt = clk_on_req ? PWR_CLOCKED : PWR_POWERED;
            default: pwr_nxt = PWR_NO_MEDIA;
        endcase
        if (~pres_q_r | ~power_on_req)
            pwr_nxt = PWR_NO_MEDIA;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pwr_r <= PWR_NO_MEDIA;
            irq_out <= ~ACTIVE_HIGH;
            wake_out <= ~ACTIVE_HIGH;
            slot_summary <= 1'b0;
        end else begin
            pwr_r <= pwr_nxt;
            irq_out <= irq_lvl ~^ ACTIVE_HIGH;
            wake_out <= wake_lvl ~^ ACTIVE_HIGH;
            slot_summary <= irq_lvl | wake_lvl;
        end
    end

    // ------------------------------------------------------------
    // status and buffer mirrors
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            norm_status <= '0;
            err_status <= '0;
            buf_writable <= 1'b0;
            buf_readable <= 1'b0;
        end else begin
            norm_status <= nb.status;
            err_status <= eb.status;
            buf_writable <= wr_en_r;
            buf_readable <= rd_en_r;
        end
    end

    // ------------------------------------------------------------
    // power condition bits
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            int_clk_on <= 1'b0;
            media_present <= 1'b0;
            media_power_on <= 1'b0;
            media_clk_on <= 1'b0;
            media_bus_clock_en <= 1'b0;
            cmd_line_busy <= 1'b0;
            dat_line_busy <= 1'b0;
        end else begin
            int_clk_on <= int_clk_en;
            media_present <= pres_q_r;
            media_power_on <= power_lvl;
            media_clk_on <= clock_lvl;
            media_bus_clock_en <= clock_lvl;
            cmd_line_busy <= cmd_busy_in;
            dat_line_busy <= xfer_act_r | busy_q_r;
        end
    end
endmodule // irq_wakeup_ctrl

// ---- bench/irq_wake_checker.sv ----
// irq_wake_checker: port checks for irq_wakeup_ctrl
// assumes bind below, default parameters, active-high lines
`timescale 1ns/1ps
module irq_wake_checker
    import irq_wake_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // software side
    input wire irq_wake_pkg::norm_vec_t norm_stat_en,
    input wire irq_wake_pkg::norm_vec_t norm_sig_en,
    input wire irq_wake_pkg::err_vec_t err_sig_en,
    input wire irq_wake_pkg::wake_vec_t wake_en,
    input wire irq_wake_pkg::norm_vec_t norm_clr_w1,
    input wire irq_wake_pkg::norm_vec_t norm_event,
    // outputs
    input wire irq_wake_pkg::norm_vec_t norm_status,
    input wire irq_wake_pkg::err_vec_t err_status,
    input wire logic slot_summary,
    input wire logic media_present,
    input wire logic media_power_on,
    input wire logic media_clk_on,
    input wire logic irq_out,
    input wire logic wake_out
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ----
    // status bit 0, lines, power and reset
    // ----
    sequence armed_s;
        norm_stat_en[0] && !norm_clr_w1[0] ##1 norm_status[0];
    endsequence
    set_latch_a: assert property (norm_event[0] && norm_stat_en[0] |-> ##2 norm_status[0])
        else $error("status not latched");
    gate_clear_a: assert property (!norm_stat_en[0] |-> ##2 !norm_status[0])
        else $error("status kept without enable");
    w1_clear_a: assert property (norm_clr_w1[0] && !norm_event[0] |-> ##2 !norm_status[0])
        else $error("write one did not clear");
    bit_hold_a: assert property (armed_s |=> norm_status[0])
        else $error("status lost");
    irq_line_a: assert property (irq_out == (|(norm_status & $past(norm_sig_en)) || |(err_status & $past(err_sig_en))))
        else $error("interrupt line wrong");
    wake_line_a: assert property (wake_out == |({norm_status[7], norm_status[6], norm_status[8]} & $past(wake_en)))
        else $error("wakeup line wrong");
    summary_or_a: assert property (slot_summary == (irq_out || wake_out))
        else $error("summary wrong");
    clk_power_a: assert property (media_clk_on |-> media_power_on)
        else $error("clock without power");
    no_media_a: assert property (!media_present [*2] |-> !media_power_on && !media_clk_on)
        else $error("power without media");
    reset_zero_a: assert property (disable iff (1'b0) sys_rst |=> norm_status == 16'h0000 && !irq_out && !wake_out)
        else $error("not idle after reset");
endmodule // irq_wake_checker
bind irq_wakeup_ctrl irq_wake_checker chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .norm_stat_en(norm_stat_en),
    .norm_sig_en(norm_sig_en), .err_sig_en(err_sig_en), .wake_en(wake_en), .norm_clr_w1(norm_clr_w1),
    .norm_event(norm_event), .norm_status(norm_status), .err_status(err_status), .slot_summary(slot_summary),
    .media_present(media_present), .media_power_on(media_power_on), .media_clk_on(media_clk_on),
    .irq_out(irq_out), .wake_out(wake_out));

// ---- bench/host_line_model.sv ----
// host_line_model: processor inputs for interrupt and wakeup
// assumes active-high lines on sys_clk
`timescale 1ns/1ps
module host_line_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // lines in
    input wire logic irq_out,
    input wire logic wake_out,
    // sampled
    output logic irq_seen,
    output logic wake_seen
);
    always_ff @(posedge sys_clk) begin
        irq_seen <= !sys_rst && irq_out;
        wake_seen <= !sys_rst && wake_out;
    end
endmodule // host_line_model

// ---- bench/testbench.sv ----
// testbench: drives irq_wakeup_ctrl and checks its ports
// assumes rtl files and checker compiled first
`timescale 1ns/1ps
module testbench;
    import irq_wake_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    norm_vec_t norm_stat_en, norm_sig_en, norm_clr_w1, norm_event, norm_status;
    err_vec_t err_stat_en, err_sig_en, err_clr_w1, err_event, err_status;
    wake_vec_t wake_en;
    logic int_clk_en, power_on_req, clk_on_req, cmd_busy_in, dma_mode, xfer_is_read, xfer_start, buf_wr_stb;
    logic buf_rd_stb, media_irq_async, media_present_async, media_busy_async, media_xfer_end_async;
    logic [11:0] block_size;
    logic slot_summary, buf_writable, buf_readable, int_clk_on, media_present, media_power_on, media_clk_on;
    logic media_bus_clock_en, cmd_line_busy, dat_line_busy, irq_out, wake_out, irq_seen, wake_seen;
    int n_mismatch = 0;
    int comparisons = 0;
    // stat_en, sig_en, wake_en -> status, irq, wake; sleep rows keep sig_en low
    logic [5:0] rows [5] = '{6'h18, 6'h24, 6'h36, 6'h2D, 6'h08};
    always #10 sys_clk = ~sys_clk;
    irq_wakeup_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .norm_stat_en(norm_stat_en),
        .norm_sig_en(norm_sig_en), .err_stat_en(err_stat_en), .err_sig_en(err_sig_en), .wake_en(wake_en),
        .norm_clr_w1(norm_clr_w1), .err_clr_w1(err_clr_w1), .int_clk_en(int_clk_en), .power_on_req(power_on_req),
        .clk_on_req(clk_on_req), .cmd_busy_in(cmd_busy_in), .norm_event(norm_event), .err_event(err_event),
        .dma_mode(dma_mode), .xfer_is_read(xfer_is_read), .xfer_start(xfer_start), .buf_wr_stb(buf_wr_stb),
        .buf_rd_stb(buf_rd_stb), .block_size(block_size), .media_irq_async(media_irq_async),
        .media_present_async(media_present_async), .media_busy_async(media_busy_async),
        .media_xfer_end_async(media_xfer_end_async), .norm_status(norm_status), .err_status(err_status),
        .slot_summary(slot_summary), .buf_writable(buf_writable), .buf_readable(buf_readable),
        .int_clk_on(int_clk_on), .media_present(media_present), .media_power_on(media_power_on),
        .media_clk_on(media_clk_on), .media_bus_clock_en(media_bus_clock_en), .cmd_line_busy(cmd_line_busy),
        .dat_line_busy(dat_line_busy), .irq_out(irq_out), .wake_out(wake_out));
    host_line_model host (.sys_clk(sys_clk), .sys_rst(sys_rst), .irq_out(irq_out), .wake_out(wake_out),
        .irq_seen(irq_seen), .wake_seen(wake_seen));
    // ----
    // helpers
    // ----
    task automatic conclude;
        if (n_mismatch == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    function automatic logic probe(input int k);
        case (k)
            0: return norm_status[8];
            1: return norm_status[1];
            2: return media_clk_on;
            default: return !norm_status[8];
        endcase
    endfunction
    task automatic poll(input int k);
        int i;
        comparisons++;
        for (i = 0; i < 40 && probe(k) !== 1'b1; i++) cyc(1);
        if (i == 40) begin
            n_mismatch++;
            $display("[FAIL] %0t wait %0d timed out", $time, k);
            conclude();
        end
    endtask
    // ----
    // sequence
    // ----
    initial begin
        {norm_stat_en, norm_sig_en, norm_clr_w1, norm_event, err_stat_en, err_sig_en, err_clr_w1, err_event} = '0;
        {wake_en, int_clk_en, power_on_req, clk_on_req, cmd_busy_in, dma_mode, xfer_is_read, xfer_start} = '0;
        {buf_wr_stb, buf_rd_stb, block_size, media_irq_async, media_present_async, media_busy_async} = '0;
        media_xfer_end_async = 1'b0;
        cyc(12);
        sys_rst = 1'b0;
        chk({norm_status, irq_out, wake_out, media_power_on}, 16'h0000);
        foreach (rows[r]) begin
            {norm_stat_en[6], norm_sig_en[6], wake_en[1], norm_event[6]} = {rows[r][5:3], 1'b1};
            cyc(1);
            norm_event[6] = 1'b0;
            cyc(2);
            chk({norm_status[6], irq_out, wake_out, slot_summary}, {rows[r][2:0], |rows[r][1:0]});
            cyc(1);
            chk({irq_seen, wake_seen}, rows[r][1:0]);
            {norm_stat_en[6], norm_sig_en[6], wake_en[1]} = 3'h0;
            cyc(3);
            chk(norm_status[6], 1'b0);
        end
        {norm_stat_en[0], norm_sig_en[0], norm_event[0], err_stat_en[3], err_sig_en[3], err_event[3]} = 6'h3F;
        cyc(1);
        {norm_event[0], err_event[3]} = 2'h0;
        cyc(6);
        chk({norm_status[0], err_status[3], irq_out}, 3'h7);
        norm_clr_w1[0] = 1'b1;
        cyc(1);
        norm_clr_w1[0] = 1'b0;
        cyc(2);
        chk({norm_status[0], err_status[3], irq_out}, 3'h3);
        err_clr_w1[3] = 1'b1;
        cyc(1);
        err_clr_w1[3] = 1'b0;
        cyc(2);
        chk(irq_out, 1'b0);
        {norm_stat_en[8], wake_en[0], media_irq_async, norm_sig_en[0], err_sig_en[3]} = 5'h1C;
        poll(0);
        cyc(2);
        chk({irq_out, wake_out, slot_summary}, 3'h3);
        norm_clr_w1[8] = 1'b1;
        cyc(1);
        norm_clr_w1[8] = 1'b0;
        cyc(3);
        chk(norm_status[8], 1'b1);
        norm_stat_en[8] = 1'b0;
        cyc(3);
        chk({norm_status[8], wake_out}, 2'h0);
        norm_stat_en[8] = 1'b1;
        poll(0);
        media_irq_async = 1'b0;
        poll(3);
        {norm_stat_en[1], dma_mode, media_busy_async, xfer_start} = 4'hF;
        cyc(1);
        {xfer_start, media_xfer_end_async} = 2'h1;
        cyc(10);
        chk({norm_status[1], dat_line_busy}, 2'h1);
        media_busy_async = 1'b0;
        poll(1);
        chk(dat_line_busy, 1'b0);
        {dma_mode, media_xfer_end_async, block_size} = 14'h0004;
        for (int d = 0; d < 2; d++) begin
            {xfer_is_read, norm_stat_en[5:4], xfer_start} = {d[0], 3'h7};
            cyc(1);
            xfer_start = 1'b0;
            cyc(4);
            chk({buf_writable, buf_readable, norm_status[5:4]}, d ? 4'h7 : 4'h9);
            repeat (4) begin
                chk(d ? buf_readable : buf_writable, 1'b1);
                {buf_rd_stb, buf_wr_stb} = d ? 2'h2 : 2'h1;
                cyc(1);
                {buf_rd_stb, buf_wr_stb} = 2'h0;
                cyc(1);
            end
            cyc(2);
            chk({buf_writable, buf_readable}, 2'h0);
        end
        {media_present_async, int_clk_en, power_on_req, clk_on_req, cmd_busy_in} = 5'h1F;
        poll(2);
        chk({int_clk_on, media_present, media_power_on, cmd_line_busy, dat_line_busy}, 5'h1F);
        power_on_req = 1'b0;
        cyc(6);
        chk({media_power_on, media_clk_on, media_bus_clock_en}, 3'h0);
        power_on_req = 1'b1;
        poll(2);
        media_present_async = 1'b0;
        cyc(8);
        chk({int_clk_on, media_power_on, media_clk_on, dat_line_busy}, 4'h8);
        int_clk_en = 1'b0;
        cyc(2);
        chk(int_clk_on, 1'b0);
        sys_rst = 1'b1;
        cyc(2);
        chk({norm_status, irq_out, int_clk_on}, 18'h0);
        sys_rst = 1'b0;
        cyc(2);
        conclude();
    end
endmodule // testbench
